// >>> shared/ca_pkg.sv
// Constants for the counter array and watchdog control block
package ca_pkg;
  // Register addresses on the special function register port
  localparam logic [7:0] ADDR_CONTROL = 8'hd8;
  localparam logic [7:0] ADDR_MODE = 8'hd9;
  localparam logic [7:0] ADDR_MOD0_MODE = 8'hda;
  localparam logic [7:0] ADDR_MOD1_MODE = 8'hdb;
  localparam logic [7:0] ADDR_MOD2_MODE = 8'hdc;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hf9;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hfa;
  localparam logic [7:0] ADDR_MOD0_LOW = 8'hfb;
  localparam logic [7:0] ADDR_MOD0_HIGH = 8'hfc;
  localparam logic [7:0] ADDR_MOD1_LOW = 8'he9;
  localparam logic [7:0] ADDR_MOD1_HIGH = 8'hea;
  localparam logic [7:0] ADDR_MOD2_LOW = 8'heb;
  localparam logic [7:0] ADDR_MOD2_HIGH = 8'hec;
  // Reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h40;
  localparam logic [7:0] RST_MOD_MODE = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // Control register fields
  localparam int CTL_OVF = 7;
  localparam int CTL_RUN = 6;
  localparam logic [7:0] CTL_WRITE_MASK = 8'hc7;
  // Mode register fields
  localparam int MD_IDLE = 7;
  localparam int MD_WDE = 6;
  localparam int MD_LOCK = 5;
  localparam int MD_CS_HI = 3;
  localparam int MD_CS_LO = 1;
  localparam int MD_OVF_IE = 0;
  localparam logic [7:0] MD_WRITE_MASK = 8'hef;
  // Module mode fields
  localparam int MM_PWM16 = 7;
  localparam int MM_ECOM = 6;
  localparam int MM_CAPP = 5;
  localparam int MM_CAPN = 4;
  localparam int MM_MAT = 3;
  localparam int MM_TOG = 2;
  localparam int MM_PWM = 1;
  localparam int MM_IE = 0;
  // Software timer mode forced on module 2 by the watchdog
  localparam logic [7:0] MM_SOFT_TIMER = 8'h48;
  // Clock select codes
  typedef enum logic [2:0] {
    CS_DIV12 = 3'h0,
    CS_DIV4 = 3'h1,
    CS_TIMER0 = 3'h2,
    CS_EXT_FALL = 3'h3,
    CS_SYSCLK = 3'h4,
    CS_XOSC_DIV8 = 3'h5
  } clk_sel_t;
  localparam logic [3:0] DIV12_LAST = 4'hb;
  localparam logic [3:0] DIV4_LAST = 4'h3;
  localparam int MODULES = 3;
  localparam int WD_MODULE = 2;
endpackage

// >>> core/ca_module.sv
// One capture/compare module: match, capture, toggle, frequency and PWM output
`timescale 1ns/1ps
module ca_module (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Counter state
  input wire logic tick_in,
  input wire logic [15:0] count_in,
  input wire logic low_wrap_in,
  input wire logic full_wrap_in,
  // Configuration and value
  input wire logic [7:0] mode_in,
  input wire logic [15:0] value_in,
  input wire logic watchdog_in,
  // Synchronised external pin
  input wire logic pin_in,
  // Results
  output logic match_out,
  output logic capture_out,
  output logic freq_step_out,
  output logic pwm_reload_out,
  output logic pin_out
);
  import ca_pkg::*;
  logic pin_last;
  logic pin_q;
  wire rise = pin_in & ~pin_last;
  wire fall = ~pin_in & pin_last;
  wire ecom = mode_in[MM_ECOM];
  wire pwm = mode_in[MM_PWM];
  wire tog = mode_in[MM_TOG];
  wire freq_mode = pwm & tog;
  wire pwm8 = pwm & ~tog & ~mode_in[MM_PWM16];
  wire pwm16 = pwm & ~tog & mode_in[MM_PWM16];
  wire eq16 = ecom & (count_in == value_in);
  wire eq8 = ecom & (count_in[7:0] == value_in[7:0]);
  wire eq_any = tick_in & (pwm8 | freq_mode ? eq8 : eq16);
  // flag on match; watchdog matches handled elsewhere
  assign match_out = eq_any & mode_in[MM_MAT] & ~watchdog_in;
  assign capture_out = ~watchdog_in &
    ((rise & mode_in[MM_CAPP]) | (fall & mode_in[MM_CAPN]));
  assign freq_step_out = eq_any & freq_mode;
  assign pwm_reload_out = pwm8 & low_wrap_in;
  wire wrap_end = pwm8 ? low_wrap_in : full_wrap_in;
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      pin_last <= 1'b0;
      pin_q <= 1'b0;
    end else if (clk_en_in) begin
      pin_last <= pin_in;
      if (tog & eq_any & ~watchdog_in) begin
        pin_q <= ~pin_q;
      // PWM set on match, clear on wrap
      end else if (pwm & ~tog & ~watchdog_in) begin
        if (!ecom) pin_q <= 1'b0;
        else if (tick_in & wrap_end) pin_q <= 1'b0;
        else if (eq_any & (pwm8 | pwm16)) pin_q <= 1'b1;
      end
    end
  end
  assign pin_out = pin_q;
endmodule

// >>> core/ca_control.sv
// Counter array control with watchdog, clock select, flags and mode registers
`timescale 1ns/1ps
// Function
// - Watchdog resets on low-byte wrap while module-2 high equals counter high.
// - Counter high byte counts low-byte wraps; first wrap after 256 counter ticks.
// - Writing one to module-2 flag forces reset while watchdog enabled.
// - Setting enable or lock bit enables the watchdog.
// - Lock holds watchdog until reset; otherwise clearing enable disables it.
// - Reset: watchdog on, clock divide-by-12, low byte and offset zero.
// - Mode register writes while enable bit set only clear that bit, and only if it is written zero.
// - Overflow flag set on counter wrap to zero, cleared by software.
// - Run bit stops the counter at zero, counts at one.
// - Unused control bits 5-3 and mode bit 4 read zero.
// - Module flags set on match or capture, cleared by software.
// - Idle suspend bit stops the counter while the CPU idles.
// - Clock select picks sysclk/12, /4, timer0, ext fall, sysclk, osc/8.
// - Overflow interrupt enable gates the overflow flag.
// - Width select picks 16-bit or 8-bit PWM.
// - Comparator enable turns on the counter comparison.
// - Rising and falling capture enables are independent.
// - Match enable sets the module flag on counter equality.
// - Toggle inverts output on match; with PWM gives frequency output.
// - PWM enable drives PWM on the module output pin.
// - Module interrupt enable gates that module's flag.
// - While watchdog on, write to module-2 high loads counter high plus offset.
// - Watchdog forces counter on, software timer mode, blocks counter and module-2 mode writes.
module ca_control (
  // Clock, reset and enable
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  // Special function register port
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  output logic [7:0] sfr_rdata_out,
  // System status
  input wire logic cpu_idle_in,
  input wire logic timer0_ovf_in,
  // External pins, asynchronous
  input wire logic external_count_input_in,
  input wire logic xosc_in,
  input wire logic [2:0] module_capture_pin_in,
  // Outputs
  output logic [2:0] module_output_pin_out,
  output logic irq_out,
  output logic watchdog_reset_out
);
  import ca_pkg::*;
  logic [7:0] array_control;
  logic [7:0] array_mode;
  logic [7:0] module_mode [MODULES];
  logic [7:0] mod_low [MODULES];
  logic [7:0] mod_high [MODULES];
  logic [15:0] count;
  logic [3:0] div_cnt;
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic eci_last;
  logic xosc_last;
  logic [2:0] xosc_div;
  logic wd_reset;
  logic [2:0] match;
  logic [2:0] capture;
  logic [2:0] freq_step;
  logic [2:0] pwm_reload;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage read only by the second
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else if (clk_en_in) begin
      sync1 <= {xosc_in, external_count_input_in, module_capture_pin_in};
      sync2 <= sync1;
    end
  end
  wire [2:0] cap_pin = sync2[2:0];
  wire eci_s = sync2[3];
  wire xosc_s = sync2[4];

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog state
  // enable or lock
  wire wd_on = array_mode[MD_WDE] | array_mode[MD_LOCK];
  wire [2:0] clk_sel = array_mode[MD_CS_HI:MD_CS_LO];
  wire suspended = array_mode[MD_IDLE] & cpu_idle_in;
  // run bit, forced on by watchdog
  wire running = (array_control[CTL_RUN] | wd_on) & ~suspended;
  wire eci_fall = eci_last & ~eci_s;
  wire xosc_rise = xosc_s & ~xosc_last;
  wire xosc_tick = xosc_rise & (xosc_div == 3'h7);
  // clock source selection; reserved codes never tick
  logic src_tick;
  always_comb begin
    unique case (clk_sel)
      CS_DIV12: src_tick = (div_cnt == DIV12_LAST);
      CS_DIV4: src_tick = (div_cnt[1:0] == DIV4_LAST[1:0]);
      CS_TIMER0: src_tick = timer0_ovf_in;
      CS_EXT_FALL: src_tick = eci_fall;
      CS_SYSCLK: src_tick = 1'b1;
      CS_XOSC_DIV8: src_tick = xosc_tick;
      default: src_tick = 1'b0;
    endcase
  end
  wire tick = running & src_tick;
  wire low_wrap = tick & (count[7:0] == 8'hff);
  wire full_wrap = tick & (count == 16'hffff);

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode
  wire wr_ctl = sfr_wr_in & (sfr_addr_in == ADDR_CONTROL);
  // only a disabling write passes while enable bit set
  wire wr_md = sfr_wr_in & (sfr_addr_in == ADDR_MODE) &
    (~array_mode[MD_WDE] | ~sfr_wdata_in[MD_WDE]);
  // lock bit sticks until reset; disabling keeps clock and idle bits
  wire [7:0] next_mode = array_mode[MD_WDE] ? (array_mode & ~(8'h01 << MD_WDE)) :
    ((sfr_wdata_in & MD_WRITE_MASK) | (array_mode & (8'h01 << MD_LOCK)));
  wire wr_cl = sfr_wr_in & (sfr_addr_in == ADDR_COUNT_LOW) & ~wd_on;
  wire wr_ch = sfr_wr_in & (sfr_addr_in == ADDR_COUNT_HIGH) & ~wd_on;
  wire [7:0] mm_addr [MODULES] = '{ADDR_MOD0_MODE, ADDR_MOD1_MODE, ADDR_MOD2_MODE};
  wire [7:0] lo_addr [MODULES] = '{ADDR_MOD0_LOW, ADDR_MOD1_LOW, ADDR_MOD2_LOW};
  wire [7:0] hi_addr [MODULES] = '{ADDR_MOD0_HIGH, ADDR_MOD1_HIGH, ADDR_MOD2_HIGH};
  // forced watchdog reset by writing module-2 flag
  wire force_rst = wr_ctl & wd_on & sfr_wdata_in[WD_MODULE];
  // compare high byte on low-byte wrap
  wire wd_expire = wd_on & low_wrap & (mod_high[WD_MODULE] == count[15:8]);

  ////////////////////////////////////////////////////////////////////////////
  // Counter, dividers and watchdog reset
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      count <= {RST_BYTE, RST_BYTE};
      div_cnt <= 4'h0;
      eci_last <= 1'b0;
      xosc_last <= 1'b0;
      xosc_div <= 3'h0;
      wd_reset <= 1'b0;
    end else if (clk_en_in) begin
      eci_last <= eci_s;
      xosc_last <= xosc_s;
      if (xosc_rise) xosc_div <= xosc_div + 3'h1;
      div_cnt <= (div_cnt == DIV12_LAST) ? 4'h0 : div_cnt + 4'h1;
      wd_reset <= force_rst | wd_expire;
      if (wr_cl) count[7:0] <= sfr_wdata_in;
      else if (wr_ch) count[15:8] <= sfr_wdata_in;
      else if (tick) count <= count + 16'h0001;
    end
  end
  assign watchdog_reset_out = wd_reset;

  ////////////////////////////////////////////////////////////////////////////
  // Control and mode registers
  wire [2:0] flag_set = match | capture;
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      array_control <= RST_CONTROL;
      array_mode <= RST_MODE;
    end else if (clk_en_in) begin
      if (wr_ctl) array_control <= sfr_wdata_in & CTL_WRITE_MASK;
      // hardware set wins over software clear
      if (full_wrap) array_control[CTL_OVF] <= 1'b1;
      for (int i = 0; i < MODULES; i++) begin
        if (flag_set[i]) array_control[i] <= 1'b1;
      end
      if (wr_md) array_mode <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Module registers and datapaths
  for (genvar m = 0; m < MODULES; m++) begin : g_mod
    wire wd_here = wd_on & (m == WD_MODULE);
    // module-2 mode writes blocked under watchdog
    wire wr_mm = sfr_wr_in & (sfr_addr_in == mm_addr[m]) & ~wd_here;
    wire wr_lo = sfr_wr_in & (sfr_addr_in == lo_addr[m]);
    wire wr_hi = sfr_wr_in & (sfr_addr_in == hi_addr[m]);
    wire [7:0] eff_mode = wd_here ? MM_SOFT_TIMER : module_mode[m];
    always_ff @(posedge sys_clk_in) begin
      if (!rstn_in) begin
        module_mode[m] <= RST_MOD_MODE;
        mod_low[m] <= RST_BYTE;
        mod_high[m] <= RST_BYTE;
      end else if (clk_en_in) begin
        if (wr_mm) module_mode[m] <= sfr_wdata_in;
        if (wr_lo) begin
          mod_low[m] <= sfr_wdata_in;
          if (!wd_here) module_mode[m][MM_ECOM] <= 1'b0;
        end else if (freq_step[m]) begin
          mod_low[m] <= mod_low[m] + mod_high[m];
        end else if (pwm_reload[m]) begin
          mod_low[m] <= mod_high[m];
        end
        if (wr_hi) begin
          mod_high[m] <= wd_here ? count[15:8] + mod_low[m] : sfr_wdata_in;
          if (!wd_here) module_mode[m][MM_ECOM] <= 1'b1;
        end else if (capture[m]) begin
          mod_high[m] <= count[15:8];
        end
        if (capture[m]) mod_low[m] <= count[7:0];
      end
    end
    ca_module u_mod (
      .sys_clk_in(sys_clk_in),
      .rstn_in(rstn_in),
      .clk_en_in(clk_en_in),
      .tick_in(tick),
      .count_in(count),
      .low_wrap_in(low_wrap),
      .full_wrap_in(full_wrap),
      .mode_in(eff_mode),
      .value_in({mod_high[m], mod_low[m]}),
      .watchdog_in(wd_here),
      .pin_in(cap_pin[m]),
      .match_out(match[m]),
      .capture_out(capture[m]),
      .freq_step_out(freq_step[m]),
      .pwm_reload_out(pwm_reload[m]),
      .pin_out(module_output_pin_out[m])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt request and read mux
  wire [2:0] mod_ie = {module_mode[2][MM_IE], module_mode[1][MM_IE],
                       module_mode[0][MM_IE]};
  assign irq_out = (array_control[CTL_OVF] & array_mode[MD_OVF_IE]) |
                   (|(array_control[2:0] & mod_ie));
  // unused bits already held at zero by write masks
  logic [7:0] rd;
  always_comb begin
    rd = 8'h00;
    unique case (sfr_addr_in)
      ADDR_CONTROL: rd = array_control;
      ADDR_MODE: rd = array_mode;
      ADDR_MOD0_MODE: rd = module_mode[0];
      ADDR_MOD1_MODE: rd = module_mode[1];
      ADDR_MOD2_MODE: rd = module_mode[2];
      ADDR_COUNT_LOW: rd = count[7:0];
      ADDR_COUNT_HIGH: rd = count[15:8];
      ADDR_MOD0_LOW: rd = mod_low[0];
      ADDR_MOD0_HIGH: rd = mod_high[0];
      ADDR_MOD1_LOW: rd = mod_low[1];
      ADDR_MOD1_HIGH: rd = mod_high[1];
      ADDR_MOD2_LOW: rd = mod_low[2];
      ADDR_MOD2_HIGH: rd = mod_high[2];
      default: rd = 8'h00;
    endcase
  end
  assign sfr_rdata_out = rd;
endmodule

// >>> bench/ca_checker.sv
// Property checker for the counter array control block
`timescale 1ns/1ps
module ca_checker (
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic clk_en_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic irq_out,
  input wire logic watchdog_reset_out
);
  import ca_pkg::*;
  logic wde_q;
  logic lock_q;
  logic wd_on;
  logic mode_wr;
  assign mode_wr = clk_en_in && sfr_wr_in && sfr_addr_in == ADDR_MODE;
  assign wd_on = wde_q | lock_q;
  // Shadow of the watchdog state, just enough to qualify reset checks
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      wde_q <= 1'b1;
      lock_q <= 1'b0;
    end else if (mode_wr && (!wde_q || !sfr_wdata_in[MD_WDE])) begin
      wde_q <= sfr_wdata_in[MD_WDE];
      lock_q <= lock_q | (!wde_q && sfr_wdata_in[MD_LOCK]);
    end
  end
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_force;
    clk_en_in && sfr_wr_in && sfr_addr_in == ADDR_CONTROL && sfr_wdata_in[WD_MODULE] && wd_on;
  endsequence
  sequence s_ovf_held;
    sfr_addr_in == ADDR_CONTROL && sfr_rdata_out[CTL_OVF] && !(sfr_wr_in && clk_en_in);
  endsequence
  property p_reset_mode;
    $rose(rstn_in) && sfr_addr_in == ADDR_MODE |-> sfr_rdata_out == RST_MODE;
  endproperty
  property p_unused_ctrl;
    sfr_addr_in == ADDR_CONTROL |-> sfr_rdata_out[5:3] == 3'h0;
  endproperty
  property p_unused_mode;
    sfr_addr_in == ADDR_MODE |-> !sfr_rdata_out[4];
  endproperty
  property p_force;
    s_force |=> watchdog_reset_out;
  endproperty
  property p_irq_quiet;
    sfr_addr_in == ADDR_CONTROL && !sfr_rdata_out[CTL_OVF] && sfr_rdata_out[2:0] == 3'h0
      |-> !irq_out;
  endproperty
  property p_pulse_one;
    watchdog_reset_out |=> !watchdog_reset_out;
  endproperty
  property p_only_enabled;
    watchdog_reset_out |-> $past(wd_on);
  endproperty
  property p_ovf_sticky;
    s_ovf_held ##1 (sfr_addr_in == ADDR_CONTROL) |-> sfr_rdata_out[CTL_OVF];
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("mode register not at reset value");
  a_unused_ctrl: assert property (p_unused_ctrl)
    else $error("unused control bits read nonzero");
  a_unused_mode: assert property (p_unused_mode)
    else $error("unused mode bit reads nonzero");
  a_force: assert property (p_force)
    else $error("forced watchdog reset missing");
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt with no flag set");
  a_pulse_one: assert property (p_pulse_one)
    else $error("watchdog reset pulse too long");
  a_only_enabled: assert property (p_only_enabled)
    else $error("watchdog reset while disabled");
  a_ovf_sticky: assert property (p_ovf_sticky)
    else $error("overflow flag cleared without write");
endmodule

bind ca_control ca_checker u_chk (
  .sys_clk_in(sys_clk_in),
  .rstn_in(rstn_in),
  .clk_en_in(clk_en_in),
  .sfr_addr_in(sfr_addr_in),
  .sfr_wdata_in(sfr_wdata_in),
  .sfr_wr_in(sfr_wr_in),
  .sfr_rdata_out(sfr_rdata_out),
  .irq_out(irq_out),
  .watchdog_reset_out(watchdog_reset_out)
);

// >>> bench/testbench.sv
// Self-checking bench for the counter array control block
`timescale 1ns/1ps
module testbench;
  import ca_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic [7:0] addr = ADDR_MODE;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic idle = 1'b0;
  logic t0 = 1'b0;
  logic external_count_input = 1'b0;
  logic xosc = 1'b0;
  logic [2:0] cap = 3'h0;
  logic [7:0] rdata;
  logic [2:0] pin;
  logic irq;
  logic wd_rst;
  logic rst_seen;
  logic [7:0] a;
  logic [7:0] b;
  logic [7:0] hi;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int start;
  ca_control DUT (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .clk_en_in(clk_en_in),
    .sfr_addr_in(addr), .sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rdata_out(rdata),
    .cpu_idle_in(idle), .timer0_ovf_in(t0), .external_count_input_in(external_count_input),
    .xosc_in(xosc), .module_capture_pin_in(cap), .module_output_pin_out(pin),
    .irq_out(irq), .watchdog_reset_out(wd_rst));
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc <= cyc + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Strobe drops one cycle before the next write may raise it
  task automatic wr_reg(input logic [7:0] ad, input logic [7:0] d);
    addr = ad;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    rst_seen = wd_rst;
    tick(1);
  endtask
  task automatic peek(input logic [7:0] ad, output logic [7:0] v);
    addr = ad;
    #10;
    v = rdata;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] v;
    peek(ad, v);
    chk($sformatf("register %h", ad), exp, v);
  endtask
  task automatic rate(input string name, input logic [7:0] md, input int n, input logic [7:0] d);
    wr_reg(ADDR_MODE, md);
    peek(ADDR_COUNT_LOW, a);
    tick(n);
    peek(ADDR_COUNT_LOW, b);
    chk(name, d, b - a);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(8);
    rstn_in = 1'b1;
    start = cyc;
    rd(ADDR_MODE, RST_MODE);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_MOD2_MODE, 8'h00);
    rd(ADDR_MOD2_LOW, 8'h00);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 4000 && wd_rst !== 1'b1; i++) tick(1);
    if (wd_rst !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    chk("expiry window", 8'h01, {7'h0, (cyc - start) inside {[3055:3095]}});
    $display("test watchdog_expiry done");
    peek(ADDR_COUNT_HIGH, hi);
    wr_reg(ADDR_MOD2_HIGH, 8'h77);
    rd(ADDR_MOD2_HIGH, hi);
    wr_reg(ADDR_CONTROL, 8'h04);
    chk("forced reset", 8'h01, {7'h0, rst_seen});
    wr_reg(ADDR_MODE, 8'hce);
    rd(ADDR_MODE, RST_MODE);
    $display("test watchdog_update done");
    wr_reg(ADDR_MODE, 8'h00);
    rd(ADDR_MODE, 8'h00);
    wr_reg(ADDR_MODE, 8'h19);
    rd(ADDR_MODE, 8'h09);
    wr_reg(ADDR_COUNT_LOW, 8'hfe);
    wr_reg(ADDR_COUNT_HIGH, 8'hff);
    wr_reg(ADDR_CONTROL, 8'h38);
    rd(ADDR_CONTROL, 8'h00);
    rd(ADDR_COUNT_LOW, 8'hfe);
    wr_reg(ADDR_CONTROL, 8'h40);
    for (int i = 0; i < 10 && rdata[CTL_OVF] !== 1'b1; i++) peek(ADDR_CONTROL, a);
    if (rdata[CTL_OVF] !== 1'b1) begin
      n_fail++;
      print_verdict();
    end
    rd(ADDR_CONTROL, 8'hc0);
    chk("overflow irq", 8'h01, {7'h0, irq});
    wr_reg(ADDR_CONTROL, 8'h40);
    chk("overflow irq cleared", 8'h00, {7'h0, irq});
    $display("test overflow done");
    idle = 1'b1;
    rate("idle held", 8'h88, 4, 8'h00);
    idle = 1'b0;
    rate("system clock", 8'h88, 5, 8'h06);
    clk_en_in = 1'b0;
    rate("clock enable freeze", 8'h88, 5, 8'h00);
    clk_en_in = 1'b1;
    rate("divide by 4", 8'h02, 19, 8'h05);
    rate("divide by 12", 8'h00, 23, 8'h02);
    wr_reg(ADDR_MODE, 8'h04);
    peek(ADDR_COUNT_LOW, a);
    repeat (3) begin
      t0 = 1'b1;
      tick(1);
      t0 = 1'b0;
      tick(1);
    end
    peek(ADDR_COUNT_LOW, b);
    chk("timer0 source", 8'h03, b - a);
    wr_reg(ADDR_MODE, 8'h06);
    peek(ADDR_COUNT_LOW, a);
    repeat (2) begin
      external_count_input = 1'b1;
      tick(3);
      external_count_input = 1'b0;
      tick(3);
    end
    tick(4);
    peek(ADDR_COUNT_LOW, b);
    chk("falling edge source", 8'h02, b - a);
    wr_reg(ADDR_MODE, 8'h0a);
    peek(ADDR_COUNT_LOW, a);
    repeat (16) begin
      xosc = 1'b1;
      tick(2);
      xosc = 1'b0;
      tick(2);
    end
    tick(6);
    peek(ADDR_COUNT_LOW, b);
    chk("oscillator source", 8'h02, b - a);
    $display("test clock_select done");
    wr_reg(ADDR_MODE, 8'h08);
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_COUNT_LOW, 8'h00);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_MOD0_LOW, 8'h08);
    wr_reg(ADDR_MOD0_HIGH, 8'h00);
    wr_reg(ADDR_MOD0_MODE, 8'h49);
    wr_reg(ADDR_MOD1_LOW, 8'h04);
    wr_reg(ADDR_MOD1_HIGH, 8'h00);
    wr_reg(ADDR_MOD1_MODE, 8'h4c);
    rd(ADDR_MOD1_MODE, 8'h4c);
    wr_reg(ADDR_CONTROL, 8'h40);
    tick(20);
    rd(ADDR_CONTROL, 8'h43);
    chk("module irq", 8'h01, {7'h0, irq});
    chk("toggle pin", 8'h02, {5'h0, pin});
    wr_reg(ADDR_CONTROL, 8'h40);
    wr_reg(ADDR_MOD0_MODE, 8'h11);
    cap = 3'h1;
    tick(4);
    rd(ADDR_CONTROL, 8'h40);
    cap = 3'h0;
    tick(4);
    rd(ADDR_CONTROL, 8'h41);
    wr_reg(ADDR_MOD0_MODE, 8'h10);
    chk("module irq masked", 8'h00, {7'h0, irq});
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_COUNT_LOW, 8'h7e);
    wr_reg(ADDR_COUNT_HIGH, 8'h00);
    wr_reg(ADDR_MOD2_LOW, 8'h80);
    wr_reg(ADDR_MOD2_HIGH, 8'h80);
    wr_reg(ADDR_MOD2_MODE, 8'h42);
    wr_reg(ADDR_CONTROL, 8'h40);
    tick(4);
    chk("pwm pin set on match", 8'h01, {7'h0, pin[2]});
    tick(130);
    chk("pwm pin cleared on low wrap", 8'h00, {7'h0, pin[2]});
    $display("test modules done");
    wr_reg(ADDR_CONTROL, 8'h00);
    wr_reg(ADDR_MOD2_LOW, 8'h03);
    wr_reg(ADDR_MODE, 8'h20);
    rd(ADDR_MODE, 8'h20);
    wr_reg(ADDR_MODE, 8'h00);
    rd(ADDR_MODE, 8'h20);
    peek(ADDR_COUNT_LOW, a);
    wr_reg(ADDR_COUNT_LOW, a + 8'h40);
    peek(ADDR_COUNT_LOW, b);
    chk("count write blocked", 8'h01, {7'h0, (b - a) <= 8'h01});
    wr_reg(ADDR_MOD2_HIGH, 8'h00);
    peek(ADDR_COUNT_HIGH, hi);
    rd(ADDR_MOD2_HIGH, hi + 8'h03);
    wr_reg(ADDR_CONTROL, 8'h04);
    chk("locked forced reset", 8'h01, {7'h0, rst_seen});
    $display("test lock done");
    print_verdict();
  end
endmodule
